// file: aoc_pkg.sv
// constants, register map and types of the analog output channel handshake block
`default_nettype none
package aoc_pkg;
	localparam int          NUM_CH        = 4;
	localparam int          STAMP_W       = 15;
	localparam int          MS_NS         = 1000000;
	localparam int          CLK_NS        = 4;
	localparam int          MS_CYCLES     = MS_NS / CLK_NS;

	// byte addresses
	localparam logic [11:0] CTRL_OFS      = 12'h000;
	localparam logic [11:0] CH_BASE       = 12'h010;
	localparam logic [11:0] CH_STRIDE     = 12'h010;
	localparam logic [11:0] CMD_OFS       = 12'h000;
	localparam logic [11:0] DATA_OFS      = 12'h004;
	localparam logic [11:0] STAT_OFS      = 12'h008;
	localparam logic [11:0] ECHO_OFS      = 12'h00C;

	// control register fields
	localparam int          CTRL_CALCONN  = 0;
	localparam int          CTRL_OPEN     = 1;
	localparam logic [1:0]  CTRL_RST      = 2'h0;

	// command register fields
	localparam int          CMD_W         = 9;
	localparam int          C_LLREL       = 0;
	localparam int          C_HLREL       = 1;
	localparam int          C_RREL        = 2;
	localparam int          C_CAL         = 3;
	localparam int          C_DRVLO       = 4;
	localparam int          C_DRVHI       = 5;
	localparam int          C_LOSENT      = 6;
	localparam int          C_HISENT      = 7;
	localparam int          C_DONE        = 8;

	// status register fields
	localparam int          S_LLALM       = 0;
	localparam int          S_HLALM       = 1;
	localparam int          S_RALM        = 2;
	localparam int          S_CALERR      = 3;
	localparam int          S_CALBUSY     = 4;
	localparam int          S_LOACC       = 5;
	localparam int          S_HIACC       = 6;
	localparam int          S_LOINV       = 7;
	localparam int          S_HIINV       = 8;
	localparam int          S_CALDONE     = 9;
	localparam int          S_STAMP_LSB   = 16;
	localparam logic [8:0]  CAL_FLAGS     = 9'h1E0;

	// reference points driven during calibration, and the drive reset value
	localparam logic [31:0] LOW_POINT     = 32'h0000_0000;
	localparam logic [31:0] HIGH_POINT    = 32'h41A0_0000;
	localparam logic [31:0] DATA_RST      = 32'h0000_0000;

	typedef enum logic [0:0] {
		CAL_IDLE = 1'b0,
		CAL_BUSY = 1'b1
	} aoc_cal_t;

	typedef enum logic [1:0] {
		DRV_DATA = 2'b00,
		DRV_LOW  = 2'b01,
		DRV_HIGH = 2'b10
	} aoc_drv_t;
endpackage : aoc_pkg
`default_nettype wire

// file: aoc_chan_if.sv
// per-channel link between the register front end and one channel
`default_nettype none
interface aoc_chan_if;
	logic                                   upd;
	logic [aoc_pkg::CMD_W-1:0]              cmd;
	logic [31:0]                            data;
	logic                                   cal_conn;
	logic                                   conn_open;
	logic                                   ms_tick;
	logic [31:0]                            status;
	logic [31:0]                            echo;

	modport front (output upd, output cmd, output data, output cal_conn, output conn_open, output ms_tick,
		input status, input echo);
	modport chan (input upd, input cmd, input data, input cal_conn, input conn_open, input ms_tick,
		output status, output echo);
endinterface : aoc_chan_if
`default_nettype wire

// file: aoc_chan.sv
// one output channel: command edges, calibration, alarm latches, echo and stamp
`default_nettype none
module aoc_chan (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ce,
	input  wire logic          low_ref_bad_in,
	input  wire logic          high_ref_bad_in,
	input  wire logic          low_limit_cond,
	input  wire logic          high_limit_cond,
	input  wire logic          ramp_cond,
	output logic        [31:0] drive_value,
	aoc_chan_if.chan           cif
);
	typedef struct packed {
		logic [aoc_pkg::CMD_W-1:0]   prev_cmd;
		aoc_pkg::aoc_cal_t           cal;
		aoc_pkg::aoc_drv_t           drv;
		logic                        low_alarm;
		logic                        high_alarm;
		logic                        ramp_alarm;
		logic                        cal_error;
		logic                        cal_done;
		logic                        low_acc;
		logic                        high_acc;
		logic                        low_inv;
		logic                        high_inv;
		logic [31:0]                 drive;
		logic [aoc_pkg::STAMP_W-1:0] free_ms;
		logic [aoc_pkg::STAMP_W-1:0] stamp;
	} aoc_chst_t;

	aoc_chst_t st_reg;
	aoc_chst_t st_next;
	logic [aoc_pkg::CMD_W-1:0] rise;
	logic [31:0]               drive_sel;
	logic                      bad_ref;
	logic [8:0]                flags;

	always_comb begin
		st_next = st_reg;
		rise = '0;
		drive_sel = cif.data;
		st_next.low_inv = low_ref_bad_in;
		st_next.high_inv = high_ref_bad_in;
		bad_ref = st_reg.low_inv | st_reg.high_inv;
		if (cif.ms_tick) begin
			st_next.free_ms = st_reg.free_ms + 1'b1;
		end
		if (low_limit_cond) begin
			st_next.low_alarm = 1'b1;
		end
		if (high_limit_cond) begin
			st_next.high_alarm = 1'b1;
		end
		if (ramp_cond) begin
			st_next.ramp_alarm = 1'b1;
		end
		if (cif.upd) begin
			rise = cif.cmd & ~st_reg.prev_cmd;
			st_next.prev_cmd = cif.cmd;
			if (rise[aoc_pkg::C_LLREL] && !low_limit_cond) begin
				st_next.low_alarm = 1'b0;
			end
			if (rise[aoc_pkg::C_HLREL] && !high_limit_cond) begin
				st_next.high_alarm = 1'b0;
			end
			if (rise[aoc_pkg::C_RREL] && !ramp_cond) begin
				st_next.ramp_alarm = 1'b0;
			end
			case (st_reg.cal)
				aoc_pkg::CAL_IDLE: begin
					if (cif.cmd[aoc_pkg::C_CAL]) begin
						st_next.cal = aoc_pkg::CAL_BUSY;
						st_next.low_acc = 1'b0;
						st_next.high_acc = 1'b0;
					end
				end
				aoc_pkg::CAL_BUSY: begin
					if (rise[aoc_pkg::C_DRVLO]) begin
						st_next.drv = aoc_pkg::DRV_LOW;
					end else if (rise[aoc_pkg::C_DRVHI]) begin
						st_next.drv = aoc_pkg::DRV_HIGH;
					end
					if (rise[aoc_pkg::C_LOSENT] && !st_reg.low_inv) begin
						st_next.low_acc = 1'b1;
					end
					if (rise[aoc_pkg::C_HISENT] && !st_reg.high_inv) begin
						st_next.high_acc = 1'b1;
					end
					// a change of complete command finishes only with both points accepted or a bad reference
					if (cif.cmd[aoc_pkg::C_DONE] != st_reg.prev_cmd[aoc_pkg::C_DONE]) begin
						if (st_reg.low_acc && st_reg.high_acc && !bad_ref) begin
							st_next.cal = aoc_pkg::CAL_IDLE;
							st_next.drv = aoc_pkg::DRV_DATA;
							st_next.cal_done = 1'b1;
							st_next.cal_error = 1'b0;
						end else if (bad_ref) begin
							st_next.cal = aoc_pkg::CAL_IDLE;
							st_next.drv = aoc_pkg::DRV_DATA;
							st_next.cal_error = 1'b1;
						end
					end else if (!cif.cmd[aoc_pkg::C_CAL]) begin
						// request dropped early counts as an abort
						st_next.cal = aoc_pkg::CAL_IDLE;
						st_next.drv = aoc_pkg::DRV_DATA;
						// fault only with a bad reference
						if (bad_ref) begin
							st_next.cal_error = 1'b1;
						end
					end
				end
				default: begin
					st_next.cal = aoc_pkg::CAL_IDLE;
				end
			endcase
		end
		// success held only while connection open
		if (!cif.conn_open) begin
			st_next.cal_done = 1'b0;
		end
		case (st_next.drv)
			aoc_pkg::DRV_LOW: drive_sel = aoc_pkg::LOW_POINT;
			aoc_pkg::DRV_HIGH: drive_sel = aoc_pkg::HIGH_POINT;
			default: drive_sel = cif.data;
		endcase
		st_next.drive = drive_sel;
		if (drive_sel != st_reg.drive) begin
			st_next.stamp = st_next.free_ms;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{prev_cmd: '0, cal: aoc_pkg::CAL_IDLE, drv: aoc_pkg::DRV_DATA, drive: aoc_pkg::DATA_RST,
				free_ms: '0, stamp: '0, default: 1'b0};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		flags = '0;
		flags[aoc_pkg::S_LLALM] = st_reg.low_alarm;
		flags[aoc_pkg::S_HLALM] = st_reg.high_alarm;
		flags[aoc_pkg::S_RALM] = st_reg.ramp_alarm;
		flags[aoc_pkg::S_CALERR] = st_reg.cal_error;
		flags[aoc_pkg::S_CALBUSY] = (st_reg.cal == aoc_pkg::CAL_BUSY);
		flags[aoc_pkg::S_LOACC] = st_reg.low_acc;
		flags[aoc_pkg::S_HIACC] = st_reg.high_acc;
		flags[aoc_pkg::S_LOINV] = st_reg.low_inv;
		flags[aoc_pkg::S_HIINV] = st_reg.high_inv;
		// calibration flags hidden on plain data connection
		if (!cif.cal_conn) begin
			flags = flags & ~aoc_pkg::CAL_FLAGS;
		end
	end

	assign cif.status = {1'b0, st_reg.stamp, 6'h00, st_reg.cal_done & cif.cal_conn, flags};
	assign cif.echo = st_reg.drive;
	assign drive_value = st_reg.drive;
endmodule : aoc_chan
`default_nettype wire

// file: aoc_top.sv
// apb register front end and millisecond prescaler for the output channels
`default_nettype none
module aoc_top #(
	parameter int MS_CYCLES = aoc_pkg::MS_CYCLES
) (
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                ce,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [11:0]                         paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic [aoc_pkg::NUM_CH-1:0]          low_ref_bad_in,
	input  wire logic [aoc_pkg::NUM_CH-1:0]          high_ref_bad_in,
	input  wire logic [aoc_pkg::NUM_CH-1:0]          low_limit_cond,
	input  wire logic [aoc_pkg::NUM_CH-1:0]          high_limit_cond,
	input  wire logic [aoc_pkg::NUM_CH-1:0]          ramp_cond,
	output logic      [aoc_pkg::NUM_CH-1:0][31:0]    drive_value
);
	typedef struct packed {
		logic [1:0]                                 ctrl;
		logic [aoc_pkg::NUM_CH-1:0][aoc_pkg::CMD_W-1:0] cmd;
		logic [aoc_pkg::NUM_CH-1:0][31:0]           data;
		logic [aoc_pkg::NUM_CH-1:0]                 upd;
		logic [31:0]                                presc;
		logic                                       tick;
		logic [31:0]                                rdata;
		logic                                       err;
	} aoc_topst_t;

	aoc_topst_t st_reg;
	aoc_topst_t st_next;
	logic [aoc_pkg::NUM_CH-1:0][31:0] ch_status;
	logic [aoc_pkg::NUM_CH-1:0][31:0] ch_echo;
	logic                             acc;
	logic [11:0]                      rel;
	logic [1:0]                       chn;
	logic                             in_ch;

	aoc_chan_if cif [aoc_pkg::NUM_CH] ();

	assign acc = psel & penable;
	assign rel = paddr - aoc_pkg::CH_BASE;
	assign chn = rel[5:4];
	assign in_ch = (paddr >= aoc_pkg::CH_BASE) && (rel < 12'(aoc_pkg::NUM_CH * 16)) && (paddr[1:0] == 2'b00);

	always_comb begin
		st_next = st_reg;
		st_next.upd = '0;
		st_next.tick = 1'b0;
		if (st_reg.presc == 32'(MS_CYCLES - 1)) begin
			st_next.presc = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.presc = st_reg.presc + 32'h0000_0001;
		end
		if (acc) begin
			st_next.rdata = 32'h0000_0000;
			st_next.err = 1'b0;
			if (paddr == aoc_pkg::CTRL_OFS) begin
				if (pwrite) begin
					st_next.ctrl = pwdata[1:0];
				end else begin
					st_next.rdata = {30'h0000_0000, st_reg.ctrl};
				end
			end else if (in_ch && rel[3:0] == aoc_pkg::CMD_OFS[3:0]) begin
				if (pwrite) begin
					// each command write is one update
					st_next.cmd[chn] = pwdata[aoc_pkg::CMD_W-1:0];
					st_next.upd[chn] = 1'b1;
				end else begin
					st_next.rdata = {23'h00_0000, st_reg.cmd[chn]};
				end
			end else if (in_ch && rel[3:0] == aoc_pkg::DATA_OFS[3:0]) begin
				if (pwrite) begin
					st_next.data[chn] = pwdata;
				end else begin
					st_next.rdata = st_reg.data[chn];
				end
			end else if (in_ch && rel[3:0] == aoc_pkg::STAT_OFS[3:0] && !pwrite) begin
				st_next.rdata = ch_status[chn];
			end else if (in_ch && rel[3:0] == aoc_pkg::ECHO_OFS[3:0] && !pwrite) begin
				st_next.rdata = ch_echo[chn];
			end else begin
				st_next.err = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{ctrl: aoc_pkg::CTRL_RST, data: '0, default: '0};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// zero-wait slave; read data and error come combinationally from the access cycle decode
	assign pready = 1'b1;
	assign prdata = st_next.rdata;
	assign pslverr = acc & st_next.err;

	for (genvar g = 0; g < aoc_pkg::NUM_CH; g++) begin : g_ch
		assign cif[g].upd = st_reg.upd[g];
		assign cif[g].cmd = st_reg.cmd[g];
		assign cif[g].data = st_reg.data[g];
		assign cif[g].cal_conn = st_reg.ctrl[aoc_pkg::CTRL_CALCONN];
		assign cif[g].conn_open = st_reg.ctrl[aoc_pkg::CTRL_OPEN];
		assign cif[g].ms_tick = st_reg.tick;
		assign ch_status[g] = cif[g].status;
		assign ch_echo[g] = cif[g].echo;
		aoc_chan u_chan (
			.pclk            (pclk),
			.presetn         (presetn),
			.ce              (ce),
			.low_ref_bad_in  (low_ref_bad_in[g]),
			.high_ref_bad_in (high_ref_bad_in[g]),
			.low_limit_cond  (low_limit_cond[g]),
			.high_limit_cond (high_limit_cond[g]),
			.ramp_cond       (ramp_cond[g]),
			.drive_value     (drive_value[g]),
			.cif             (cif[g].chan)
		);
	end
endmodule : aoc_top
`default_nettype wire

// file: aoc_asserts.sv
// port-level checks of the analog output channel handshake block
`default_nettype none
module aoc_asserts (
	input wire logic                               pclk,
	input wire logic                               presetn,
	input wire logic                               ce,
	input wire logic                               psel,
	input wire logic                               penable,
	input wire logic                               pwrite,
	input wire logic [11:0]                        paddr,
	input wire logic [31:0]                        pwdata,
	input wire logic [31:0]                        prdata,
	input wire logic                               pready,
	input wire logic                               pslverr,
	input wire logic [aoc_pkg::NUM_CH-1:0]         low_ref_bad_in,
	input wire logic [aoc_pkg::NUM_CH-1:0]         high_ref_bad_in,
	input wire logic [aoc_pkg::NUM_CH-1:0]         low_limit_cond,
	input wire logic [aoc_pkg::NUM_CH-1:0]         high_limit_cond,
	input wire logic [aoc_pkg::NUM_CH-1:0]         ramp_cond,
	input wire logic [aoc_pkg::NUM_CH-1:0][31:0]   drive_value
);
	// shadow of the connection type, written at the same edge as the design
	logic       cc_reg;
	// age guard keeps $past from seeing values from inside reset
	logic [1:0] age_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cc_reg  <= 1'b0;
			age_reg <= 2'h0;
		end else begin
			if (age_reg != 2'h3)
				age_reg <= age_reg + 2'h1;
			if (ce && psel && penable && pwrite && paddr == 12'h000)
				cc_reg <= pwdata[aoc_pkg::CTRL_CALCONN];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd(logic [11:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	sequence s_warm;
		age_reg == 2'h3 && $past(ce);
	endsequence
	chk_low_invalid: assert property (s_rd(12'h018) ##0 s_warm ##0 cc_reg
		|-> prdata[aoc_pkg::S_LOINV] == $past(low_ref_bad_in[0])) else $error("low invalid flag off");
	chk_high_invalid: assert property (s_rd(12'h018) ##0 s_warm ##0 cc_reg
		|-> prdata[aoc_pkg::S_HIINV] == $past(high_ref_bad_in[0])) else $error("high invalid flag off");
	chk_cal_hidden: assert property (s_rd(12'h018) ##0 !cc_reg |-> prdata[9:5] == 5'h00)
		else $error("calibration flags shown on plain connection");
	chk_echo_drive: assert property (s_rd(12'h01C) ##0 $stable(drive_value[0])
		|-> prdata == drive_value[0]) else $error("echo differs from drive");
	chk_low_alarm: assert property (s_rd(12'h018) ##0 s_warm ##0 $past(low_limit_cond[0])
		|-> prdata[aoc_pkg::S_LLALM]) else $error("low alarm not set");
	chk_high_alarm: assert property (s_rd(12'h018) ##0 s_warm ##0 $past(high_limit_cond[0])
		|-> prdata[aoc_pkg::S_HLALM]) else $error("high alarm not set");
	chk_ramp_alarm: assert property (s_rd(12'h018) ##0 s_warm ##0 $past(ramp_cond[0])
		|-> prdata[aoc_pkg::S_RALM]) else $error("ramp alarm not set");
	chk_unmapped_err: assert property (psel && penable && paddr >= 12'h050 |-> pslverr)
		else $error("unmapped access not refused");
	chk_ro_write: assert property (psel && penable && pwrite && paddr == 12'h018 |-> pslverr)
		else $error("status write not refused");
	chk_zero_wait: assert property (psel && penable |-> pready)
		else $error("access cycle stalled");
endmodule : aoc_asserts
bind aoc_top aoc_asserts chk_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.low_ref_bad_in(low_ref_bad_in), .high_ref_bad_in(high_ref_bad_in), .low_limit_cond(low_limit_cond),
	.high_limit_cond(high_limit_cond), .ramp_cond(ramp_cond), .drive_value(drive_value));
`default_nettype wire

// file: aoc_host.sv
// apb master model standing in for the host controller
`default_nettype none
module aoc_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        to;
	initial begin
		{psel, penable, pwrite, paddr, pwdata, to} = '0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 50);
		if (n >= 50)
			to = 1'b1;
		// answer taken at the ready edge itself, before that edge's updates land
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : aoc_host
`default_nettype wire

// file: test_aoc_top.sv
// self-checking bench of the analog output channel handshake block
`default_nettype none
module test_aoc_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] CTRL  = 12'h000;
	localparam logic [11:0] CMD0  = 12'h010;
	localparam logic [11:0] DATA0 = 12'h014;
	localparam logic [11:0] STAT0 = 12'h018;
	localparam logic [11:0] ECHO0 = 12'h01C;
	localparam int          MSC   = 10;
	logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata;
	logic [3:0]        lob, hib;
	logic [3:0]        cnd [3];
	logic [3:0][31:0]  drive_value;
	int                err_total, cmp_count, cyc;
	aoc_top #(.MS_CYCLES(MSC)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_ref_bad_in(lob), .high_ref_bad_in(hib), .low_limit_cond(cnd[0]), .high_limit_cond(cnd[1]),
		.ramp_cond(cnd[2]), .drive_value(drive_value));
	aoc_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic finish_test();
		if (host_u.to)
			err_total++;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		host_u.xfer(w, a, d, q, e);
		if (host_u.to)
			finish_test();
	endtask : bus
	// command effects land one edge after the write; two spare edges
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		bus(1'b1, a, d, q, e);
		repeat (3) @(posedge pclk);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		bus(1'b0, a, 32'h0000_0000, q, e);
	endtask : rd
	task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask : cmp
	task automatic cst(input string nm, input int b, input logic x);
		logic [31:0] q;
		rd(STAT0, q);
		cmp(nm, {31'h0, x}, {31'h0, q[b]});
	endtask : cst
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		rd(CMD0, q);
		cmp("cmd reset", 32'h0000_0000, q);
		rd(STAT0, q);
		cmp("status reset", 32'h0000_0000, q);
		bus(1'b0, 12'h050, 32'h0000_0000, q, e);
		cmp("unmapped err", 32'h0000_0001, {31'h0, e});
		bus(1'b1, STAT0, 32'hFFFF_FFFF, q, e);
		cmp("read-only err", 32'h0000_0001, {31'h0, e});
	endtask : t_reset
	task automatic t_alarms();
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			cnd[i][0] <= 1'b1;
			cst("alarm raised", i, 1'b1);
			// release while the condition still stands: the set wins
			wr(CMD0, 32'h0000_0001 << i);
			cst("release refused", i, 1'b1);
			cnd[i][0] <= 1'b0;
			wr(CMD0, 32'h0000_0000);
			cst("alarm latched", i, 1'b1);
			wr(CMD0, 32'h0000_0001 << i);
			cst("alarm released", i, 1'b0);
		end
		wr(CMD0, 32'h0000_0000);
	endtask : t_alarms
	task automatic t_fault();
		logic [31:0] q;
		wr(CTRL, 32'h0000_0003);
		lob <= 4'h1;
		hib <= 4'h1;
		cst("low invalid", 7, 1'b1);
		cst("high invalid", 8, 1'b1);
		wr(CMD0, 32'h0000_0008);
		cst("calibrating", 4, 1'b1);
		wr(CMD0, 32'h0000_0000);
		cst("fault set", 3, 1'b1);
		wr(CTRL, 32'h0000_0002);
		rd(STAT0, q);
		cmp("flags hidden", 32'h0000_0000, q & 32'h0000_03E0);
		lob <= 4'h0;
		hib <= 4'h0;
		wr(CTRL, 32'h0000_0003);
		cst("low invalid gone", 7, 1'b0);
	endtask : t_fault
	// drop the low drive command in the same write that raises the high one: never both at once
	task automatic t_cal_ok();
		logic [31:0] q;
		wr(DATA0, 32'h3F80_0000);
		wr(CMD0, 32'h0000_0008);
		wr(CMD0, 32'h0000_0018);
		cmp("drive low", aoc_pkg::LOW_POINT, drive_value[0]);
		wr(CMD0, 32'h0000_0028);
		cmp("drive high", aoc_pkg::HIGH_POINT, drive_value[0]);
		wr(CMD0, 32'h0000_0048);
		cst("low accepted", 5, 1'b1);
		wr(CMD0, 32'h0000_0088);
		cst("high accepted", 6, 1'b1);
		cst("fault held", 3, 1'b1);
		wr(CMD0, 32'h0000_0188);
		cst("cal done", 9, 1'b1);
		cst("fault cleared", 3, 1'b0);
		cst("cal left", 4, 1'b0);
		cmp("drive data", 32'h3F80_0000, drive_value[0]);
		rd(ECHO0, q);
		cmp("echo", 32'h3F80_0000, q);
		wr(CTRL, 32'h0000_0001);
		cst("done dropped", 9, 1'b0);
	endtask : t_cal_ok
	task automatic t_stamp();
		logic [31:0] q;
		logic [14:0] s1, d;
		logic        e;
		int          c1, ex;
		wr(DATA0, 32'h4000_0000);
		c1 = cyc;
		rd(STAT0, q);
		s1 = q[30:16];
		repeat (200) @(posedge pclk);
		rd(STAT0, q);
		cmp("stamp held", {17'h0, s1}, {17'h0, q[30:16]});
		wr(DATA0, 32'h4040_0000);
		ex = (cyc - c1) / MSC;
		rd(STAT0, q);
		d = q[30:16] - s1;
		cmp("stamp step", 32'h0000_0001, {31'h0, int'(d) >= ex - 1 && int'(d) <= ex + 1});
		@(posedge pclk);
		ce <= 1'b0;
		bus(1'b1, DATA0, 32'h1234_5678, q, e);
		ce <= 1'b1;
		rd(DATA0, q);
		cmp("frozen write", 32'h4040_0000, q);
	endtask : t_stamp
	initial begin
		presetn   = 1'b0;
		ce        = 1'b1;
		lob       = 4'h0;
		hib       = 4'h0;
		cnd       = '{default: 4'h0};
		err_total = 0;
		cmp_count = 0;
		cyc       = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_alarms();
		t_fault();
		t_cal_ok();
		t_stamp();
		finish_test();
	end
endmodule : test_aoc_top
`default_nettype wire
